// *** logic/sacct_corr.sv ***
/*
 * Correction adder: aligns the coarse and fine codes, adds them and
 * saturates on carry out or full scale.
 * Assumes its input is a registered pipeline word; output is registered.
 */
`timescale 1ns/100ps
module sacct_corr
    import sacct_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire sacct_pipe_t i_pipe,
    input wire logic i_full_scale,
    output logic [OUT_W-1:0] o_word,
    output logic o_ovr
);
    // ------------------------------------------------------------------
    // Operand alignment and sum
    // ------------------------------------------------------------------
    wire logic [OUT_W-1:0] op_coarse;
    wire logic [OUT_W-1:0] op_fine;
    wire logic [OUT_W:0] sum13;
    wire logic ovr;
    wire logic [OUT_W-1:0] nxt_word;
    logic [OUT_W-1:0] word_ff;
    logic ovr_ff;

    assign op_coarse = {i_pipe.coarse, {PAD_W{1'b0}}};
    assign op_fine = {{PAD_W{1'b0}}, i_pipe.fine};
    assign sum13 = {1'b0, op_coarse} + {1'b0, op_fine};
    assign ovr = sum13[OUT_W] | i_full_scale;
    assign nxt_word = ovr ? OUT_ALL_ONES : sum13[OUT_W-1:0];

    // Register the corrected word on load
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            word_ff <= 12'h0000;
            ovr_ff <= 1'b0;
        end else if (i_load) begin
            word_ff <= nxt_word;
            ovr_ff <= ovr;
        end
    end

    assign o_word = word_ff;
    assign o_ovr = ovr_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sat_on_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_load && (sum13[OUT_W] || i_full_scale) |=> o_word == OUT_ALL_ONES)
        else $error("overrange word not saturated");
    sum_plain_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_load && !ovr |=> o_word == $past(op_coarse) + $past(op_fine))
        else $error("corrected sum wrong");
    ovr_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_load |=> o_ovr == $past(sum13[OUT_W] | i_full_scale))
        else $error("overrange flag wrong");
endmodule

// *** logic/sacct_pkg.sv ***
/*
 * Package for the subranging converter timing and correction block.
 * Holds timing constants, code widths and the carrier structs.
 * Assumes a 125 MHz system clock (8 ns period).
 */
package sacct_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int OSC_HZ = 20000000;
    localparam int OSC_PERIOD_PS = 1000000000 / (OSC_HZ / 1000);
    // Oscillator half period in cycles, rounded down, at least one
    localparam int OSC_HALF_CYC_RAW = (OSC_PERIOD_PS / 2) / CLK_PERIOD_PS;
    localparam int OSC_HALF_CYC = (OSC_HALF_CYC_RAW < 1) ? 1 :
        OSC_HALF_CYC_RAW;
    localparam int MIN_CMD_PULSE_NS = 10;
    localparam int MAX_DUTY_PCT = 80;
    localparam int CONV_TIME_NS = 135;
    localparam int ACQ_NS = 65;
    localparam int COARSE_SETTLE_NS = 65;
    localparam int FINE_SETTLE_NS = 85;
    localparam int DV_DELAY_NS = 6;
    localparam int MAX_RATE_HZ = 5000000;
    // Least times, rounded up to whole cycles
    localparam int CONV_CYC = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int ACQ_CYC = (ACQ_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int COARSE_CYC = (COARSE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int FINE_CYC = (FINE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int DV_CYC = (DV_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Code widths
    // ------------------------------------------------------------------
    localparam int ENC_W = 7;
    localparam int OUT_W = 12;
    localparam int PIPE_W = 14;
    localparam int PAD_W = 5;
    localparam logic [OUT_W-1:0] OUT_ALL_ONES = 12'h0fff;
    localparam logic [ENC_W-1:0] ENC_RST = 7'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // Timing gates to the analog chain
    typedef struct packed {
        logic sh_gate;
        logic blank;
        logic enc_coarse_sel;
        logic enc_strobe;
    } sacct_gates_t;

    // Coarse and fine codes held together
    typedef struct packed {
        logic [ENC_W-1:0] coarse;
        logic [ENC_W-1:0] fine;
    } sacct_pipe_t;
endpackage

// *** logic/sacct_top.sv ***
/*
 * Timing and error correction for a two-step subranging 12-bit
 * converter. Sequences sample/hold, coarse and fine encodes, holds the
 * codes, corrects them and strobes a data valid pulse.
 * Assumes the convert command and encoder code are asynchronous pins,
 * synchronised here; the reset is a system reset (the analog part has
 * none). A 20 MHz oscillator is modelled by a divider.
 */
`timescale 1ns/100ps
module sacct_top
    import sacct_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_convert,
    input wire logic [ENC_W-1:0] i_enc_code,
    input wire logic i_full_scale,
    input wire logic i_pipe_sel,
    output sacct_gates_t o_gates,
    output logic [OUT_W-1:0] o_data,
    output logic o_output_ready_strobe,
    output logic o_overrange
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic cmd_s1_ff;
    logic cmd_s2_ff;
    logic cmd_d_ff;
    logic sel_s1_ff;
    logic sel_s2_ff;
    logic fs_s1_ff;
    logic fs_s2_ff;
    logic [ENC_W-1:0] enc_s1_ff;
    logic [ENC_W-1:0] enc_s2_ff;

    // Two flops per pin before any logic reads it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_s1_ff <= 1'b0;
            cmd_s2_ff <= 1'b0;
            cmd_d_ff <= 1'b0;
            sel_s1_ff <= 1'b0;
            sel_s2_ff <= 1'b0;
            fs_s1_ff <= 1'b0;
            fs_s2_ff <= 1'b0;
            enc_s1_ff <= ENC_RST;
            enc_s2_ff <= ENC_RST;
        end else begin
            cmd_s1_ff <= i_convert;
            cmd_s2_ff <= cmd_s1_ff;
            cmd_d_ff <= cmd_s2_ff;
            sel_s1_ff <= i_pipe_sel;
            sel_s2_ff <= sel_s1_ff;
            fs_s1_ff <= i_full_scale;
            fs_s2_ff <= fs_s1_ff;
            enc_s1_ff <= i_enc_code;
            enc_s2_ff <= enc_s1_ff;
        end
    end

    // Rising edge of command; width does not matter
    wire logic cmd_rise;
    assign cmd_rise = cmd_s2_ff & ~cmd_d_ff;

    // ------------------------------------------------------------------
    // Command period measurement
    // ------------------------------------------------------------------
    localparam int PER_W = 16;
    logic [PER_W-1:0] per_cnt_ff;
    wire logic [PER_W-1:0] conv_cyc_w;
    wire logic [PER_W-1:0] sh_len;
    assign conv_cyc_w = PER_W'(CONV_CYC);
    // Gate length is the period just ended less the conversion interval
    assign sh_len = (per_cnt_ff > conv_cyc_w) ? per_cnt_ff - conv_cyc_w :
        PER_W'(ACQ_CYC);

    // Count cycles between command edges
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            per_cnt_ff <= '0;
        end else if (cmd_rise) begin
            per_cnt_ff <= PER_W'(1);
        end else if (per_cnt_ff != '1) begin
            per_cnt_ff <= per_cnt_ff + PER_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Oscillator synchronised to the command, and three-stage shifter
    // ------------------------------------------------------------------
    localparam int OSC_W = 4;
    logic [OSC_W-1:0] osc_cnt_ff;
    logic osc_ff;
    logic [2:0] shr_ff;
    wire logic osc_tick;
    assign osc_tick = (osc_cnt_ff == OSC_W'(OSC_HALF_CYC - 1)) & osc_ff;

    // Oscillator restarts in phase at each command edge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            osc_cnt_ff <= '0;
            osc_ff <= 1'b0;
        end else if (cmd_rise) begin
            osc_cnt_ff <= '0;
            osc_ff <= 1'b0;
        end else if (osc_cnt_ff == OSC_W'(OSC_HALF_CYC - 1)) begin
            osc_cnt_ff <= '0;
            osc_ff <= ~osc_ff;
        end else begin
            osc_cnt_ff <= osc_cnt_ff + OSC_W'(1);
        end
    end

    // Shift register restarts at each command edge and shifts on each oscillator tick
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shr_ff <= 3'b000;
        end else if (cmd_rise) begin
            shr_ff <= 3'b001;
        end else if (osc_tick) begin
            shr_ff <= {shr_ff[1:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000,
        SQ_ACQ = 3'b001,
        SQ_CSETTLE = 3'b010,
        SQ_FSETTLE = 3'b011,
        SQ_FINE = 3'b100,
        SQ_OUT = 3'b101
    } sacct_seq_t;
    sacct_seq_t st_ff;
    sacct_seq_t nxt_st;
    logic [PER_W-1:0] tcnt_ff;
    logic [PER_W-1:0] nxt_tcnt;
    wire logic t_done;
    wire logic phase_ok;
    assign t_done = (tcnt_ff == '0);
    assign phase_ok = shr_ff[2] | (tcnt_ff == '0);

    // Next state and phase timer
    always_comb begin
        nxt_st = st_ff;
        nxt_tcnt = (tcnt_ff == '0) ? tcnt_ff : tcnt_ff - PER_W'(1);
        if (cmd_rise) begin
            nxt_st = SQ_ACQ;
            nxt_tcnt = sh_len - PER_W'(1);
        end else begin
            case (st_ff)
                SQ_IDLE: begin
                    nxt_st = SQ_IDLE;
                end
                SQ_ACQ: begin
                    if (t_done && phase_ok) begin
                        nxt_st = SQ_CSETTLE;
                        nxt_tcnt = PER_W'(COARSE_CYC - 1);
                    end
                end
                SQ_CSETTLE: begin
                    if (t_done) begin
                        nxt_st = SQ_FSETTLE;
                        nxt_tcnt = PER_W'(FINE_CYC - 1);
                    end
                end
                SQ_FSETTLE: begin
                    if (t_done) begin
                        nxt_st = SQ_FINE;
                    end
                end
                SQ_FINE: begin
                    nxt_st = SQ_OUT;
                    nxt_tcnt = PER_W'(DV_CYC - 1);
                end
                SQ_OUT: begin
                    if (t_done) begin
                        nxt_st = SQ_IDLE;
                    end
                end
                default: begin
                    nxt_st = SQ_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= SQ_IDLE;
            tcnt_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            tcnt_ff <= nxt_tcnt;
        end
    end

    // ------------------------------------------------------------------
    // Gates, holding registers and pipeline word
    // ------------------------------------------------------------------
    wire logic coarse_cap;
    wire logic fine_cap;
    assign coarse_cap = (st_ff == SQ_CSETTLE) && t_done;
    assign fine_cap = (st_ff == SQ_FINE);
    sacct_gates_t gates_ff;
    sacct_gates_t nxt_gates;
    logic [ENC_W-1:0] coarse_ff;
    logic [ENC_W-1:0] fine_ff;
    sacct_pipe_t pipe_ff;
    logic pipe_ld_ff;
    logic fs_hold_ff;

    // Gate levels from next state
    always_comb begin
        nxt_gates.sh_gate = (nxt_st == SQ_ACQ);
        nxt_gates.blank = (nxt_st == SQ_ACQ) || (nxt_st == SQ_CSETTLE);
        nxt_gates.enc_coarse_sel = (nxt_st != SQ_FSETTLE) &&
            (nxt_st != SQ_FINE);
        nxt_gates.enc_strobe = (nxt_st == SQ_FINE);
    end

    // Capture codes into separate holds, then the pipeline word
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gates_ff <= '0;
            coarse_ff <= ENC_RST;
            fine_ff <= ENC_RST;
            pipe_ff <= '0;
            pipe_ld_ff <= 1'b0;
            fs_hold_ff <= 1'b0;
        end else begin
            gates_ff <= nxt_gates;
            pipe_ld_ff <= fine_cap;
            if (coarse_cap) begin
                coarse_ff <= enc_s2_ff;
                fs_hold_ff <= fs_s2_ff;
            end
            if (fine_cap) begin
                fine_ff <= enc_s2_ff;
            end
            if (pipe_ld_ff) begin
                pipe_ff <= '{coarse: coarse_ff, fine: fine_ff};
            end
        end
    end

    // ------------------------------------------------------------------
    // Correction and output
    // ------------------------------------------------------------------
    logic corr_ld_ff;
    wire logic [OUT_W-1:0] corr_word;
    wire logic corr_ovr;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            corr_ld_ff <= 1'b0;
        end else begin
            corr_ld_ff <= pipe_ld_ff;
        end
    end

    sacct_corr u_corr (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_load(corr_ld_ff),
        .i_pipe(pipe_ff),
        .i_full_scale(fs_hold_ff),
        .o_word(corr_word),
        .o_ovr(corr_ovr)
    );

    logic [OUT_W-1:0] data_ff;
    logic ovr_ff;
    logic rdy_ff;
    logic [PER_W-1:0] dvcnt_ff;
    logic word_new_ff;
    logic corr_done_ff;
    wire logic dv_fire;
    assign dv_fire = word_new_ff && (dvcnt_ff == PER_W'(DV_CYC - 1));

    // Output word: on completion, or on command when delay select high
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data_ff <= 12'h0000;
            ovr_ff <= 1'b0;
            rdy_ff <= 1'b0;
            dvcnt_ff <= '0;
            word_new_ff <= 1'b0;
            corr_done_ff <= 1'b0;
        end else begin
            corr_done_ff <= corr_ld_ff;
            rdy_ff <= dv_fire;
            if ((corr_done_ff && !sel_s2_ff) || (cmd_rise && sel_s2_ff)) begin
                data_ff <= corr_word;
                ovr_ff <= corr_ovr;
                word_new_ff <= 1'b1;
                dvcnt_ff <= '0;
            end else if (dv_fire) begin
                word_new_ff <= 1'b0;
            end else if (word_new_ff) begin
                dvcnt_ff <= dvcnt_ff + PER_W'(1);
            end
        end
    end

    assign o_gates = gates_ff;
    assign o_data = data_ff;
    assign o_output_ready_strobe = rdy_ff;
    assign o_overrange = ovr_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    cmd_starts_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cmd_rise |=> st_ff == SQ_ACQ)
        else $error("command edge did not start conversion");
    shr_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cmd_rise |=> shr_ff == 3'b001)
        else $error("shift register not restarted");
    coarse_settle_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(st_ff == SQ_CSETTLE) |->
        (st_ff == SQ_CSETTLE)[*8] ##1 (st_ff == SQ_CSETTLE))
        else $error("coarse settle too short");
    blank_span_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (st_ff == SQ_ACQ || st_ff == SQ_CSETTLE) |-> o_gates.blank)
        else $error("blanking dropped early");
    fine_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        st_ff == SQ_FINE |-> !o_gates.enc_coarse_sel)
        else $error("fine encode not selected");
    hold_coarse_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        coarse_cap |=> coarse_ff == $past(enc_s2_ff))
        else $error("coarse hold not captured");
    pipe_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        fine_cap |-> ##2 pipe_ff.fine == $past(enc_s2_ff, 2))
        else $error("pipeline word missed fine code");
    strobe_delay_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(word_new_ff) && !sel_s2_ff |-> ##[1:2] rdy_ff)
        else $error("ready strobe late");
    sel_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cmd_rise && sel_s2_ff |=> o_data == $past(corr_word))
        else $error("command read wrong word");
    cv_conv: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        st_ff == SQ_FINE ##[1:20] rdy_ff);
    cv_sat: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        rdy_ff && o_overrange);
    cv_sel: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        cmd_rise && sel_s2_ff);
endmodule

// *** verification/sacct_far_model.sv ***
/*
 * Far side model: the shared encoder bus that answers the coarse/fine
 * selection, and the outside latch that captures each output word.
 * Assumes the gates are registered levels, sampled at the falling edge.
 */
`timescale 1ns/100ps
module sacct_far_model
    import sacct_pkg::*;
(
    input wire logic i_clk,
    input wire sacct_gates_t i_gates,
    input wire logic [ENC_W-1:0] i_coarse,
    input wire logic [ENC_W-1:0] i_fine,
    input wire logic [OUT_W-1:0] i_data,
    input wire logic i_strobe,
    output logic [ENC_W-1:0] o_enc_code,
    output logic [OUT_W-1:0] o_latched
);
    // ------------------------------------------------------------------
    // Encoder bus
    // ------------------------------------------------------------------
    initial o_enc_code = '0;
    // Unsettled pattern while sampling, then coarse, then fine
    always @(negedge i_clk) begin
        if (i_gates.sh_gate) begin
            o_enc_code <= ~o_enc_code;
        end else if (i_gates.enc_coarse_sel) begin
            o_enc_code <= i_coarse;
        end else begin
            o_enc_code <= i_fine;
        end
    end

    // ------------------------------------------------------------------
    // Outside output latch
    // ------------------------------------------------------------------
    initial o_latched = '0;
    // Captures the word on each data valid pulse
    always @(posedge i_clk) begin
        if (i_strobe) begin
            o_latched <= i_data;
        end
    end
endmodule

// *** verification/subranging_adc_correction_timing_tb.sv ***
/*
 * Testbench: drives convert commands, codes and full scale, and checks
 * gate timing and every word read out against a model in the bench.
 * Assumes the far side model answers the encoder selection.
 */
`timescale 1ns/100ps
module subranging_adc_correction_timing_tb
    import sacct_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_convert = 1'b0;
    logic i_full_scale = 1'b0;
    logic i_pipe_sel = 1'b0;
    logic [ENC_W-1:0] enc_code;
    logic [ENC_W-1:0] coarse = '0;
    logic [ENC_W-1:0] fine = '0;
    sacct_gates_t o_gates;
    logic [OUT_W-1:0] o_data;
    logic o_output_ready_strobe;
    logic o_overrange;
    logic [OUT_W-1:0] latched;
    int n_mismatch = 0;
    int checks = 0;
    logic [OUT_W:0] expq[$]; // Expected {overrange, word}
    int shq[$]; // Expected gate widths
    logic [OUT_W:0] last_e = '0;
    int prev_gap = 0;

    // 8 ns clock
    always #4 i_clk = ~i_clk;

    sacct_top dut_u (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_convert(i_convert),
        .i_enc_code(enc_code),
        .i_full_scale(i_full_scale),
        .i_pipe_sel(i_pipe_sel),
        .o_gates(o_gates),
        .o_data(o_data),
        .o_output_ready_strobe(o_output_ready_strobe),
        .o_overrange(o_overrange)
    );

    sacct_far_model far_u (
        .i_clk(i_clk),
        .i_gates(o_gates),
        .i_coarse(coarse),
        .i_fine(fine),
        .i_data(o_data),
        .i_strobe(o_output_ready_strobe),
        .o_enc_code(enc_code),
        .o_latched(latched)
    );

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One command; keep says whether its result is expected to appear
    task automatic conv(input int gap, input bit keep,
        input logic [6:0] c, input logic [6:0] f, input logic fs);
        int s;
        int w;
        s = c * 32 + f;
        w = (gap % 2) ? 2 : gap * 4 / 5;
        shq.push_back((prev_gap <= CONV_CYC) ? ACQ_CYC :
            prev_gap - CONV_CYC);
        prev_gap = gap;
        if (keep) begin
            last_e = (fs || s > 4095) ? 13'h1_fff : 13'(s);
            expq.push_back(last_e);
        end
        coarse = c;
        fine = f;
        i_full_scale = fs;
        i_convert = 1'b1;
        repeat (w) @(negedge i_clk);
        i_convert = 1'b0;
        repeat (gap - w) @(negedge i_clk);
    endtask

    // ------------------------------------------------------------------
    // Monitor of gates and results
    // ------------------------------------------------------------------
    int st = 0;
    int cnt = 0;
    logic [OUT_W:0] e;
    logic [OUT_W-1:0] data_d = '0;
    logic latch_due = 1'b0;
    logic [OUT_W-1:0] latch_exp = '0;
    always @(negedge i_clk) begin
        cnt++;
        if (latch_due) chk(latched, latch_exp);
        latch_due = 1'b0;
        // Gate opening, closing, coarse update and fine strobe
        if (i_rst_b && o_gates.sh_gate === 1'b1 && st != 1) begin
            st = 1;
            cnt = 1;
            chk(o_gates.blank, 1);
            chk(o_gates.enc_coarse_sel, 1);
        end else if (st == 1 && o_gates.sh_gate === 1'b0) begin
            chk(cnt - 1, shq.pop_front());
            chk(o_gates.blank, 1);
            st = 2;
            cnt = 0;
        end else if (st == 2 && o_gates.enc_coarse_sel === 1'b0) begin
            chk(cnt, COARSE_CYC);
            chk(o_gates.blank, 0);
            st = 3;
            cnt = 0;
        end else if (st == 3 && o_gates.enc_strobe === 1'b1) begin
            chk(cnt, FINE_CYC);
            st = i_pipe_sel ? 0 : 4;
            cnt = 0;
        end
        // Result word on each data valid pulse
        if (o_output_ready_strobe === 1'b1) begin
            if (st == 4) chk(cnt, 4 + DV_CYC);
            if (st == 4) st = 0;
            chk(expq.size() > 0, 1);
            e = expq.pop_front();
            chk(o_data, e[OUT_W-1:0]);
            chk(o_overrange, e[OUT_W]);
            chk(o_data, data_d);
            latch_due = 1'b1;
            latch_exp = e[OUT_W-1:0];
        end
        data_d = o_data;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'he702_148e));
        repeat (12) @(negedge i_clk);
        i_rst_b = 1'b1;
        @(negedge i_clk);
        chk(o_data, 0);
        chk(o_output_ready_strobe, 0);
        chk(o_overrange, 0);
        // Delay select low: boundary codes, an abort, random codes
        conv(45, 1, 7'h7f, 7'h7f, 1'b0);
        conv(60, 1, 7'h7f, 7'h1f, 1'b0);
        conv(75, 1, 7'h00, 7'h00, 1'b1);
        conv(70, 0, 7'($urandom), 7'($urandom), 1'b0);
        conv(85, 1, 7'($urandom), 7'($urandom), 1'b0);
        conv(120, 1, 7'($urandom), 7'($urandom), 1'b1);
        // Delay select high: each command reads the previous word
        i_pipe_sel = 1'b1;
        expq.push_back(last_e);
        for (int k = 0; k < 4; k++) begin
            conv(135 + k * 15, k < 3, 7'($urandom), 7'($urandom),
                ($urandom % 8) == 0);
        end
        chk(expq.size(), 0);
        summarize();
    end

    // Watchdog against a hang
    initial begin
        repeat (4000) @(posedge i_clk);
        n_mismatch++;
        summarize();
    end
endmodule
